// [include/wwdt_pkg.sv]
`default_nettype none

package wwdt_pkg;

   // ------------------------------------------------------------
   // timing base
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_NS       = 1000;
   localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // factory times, in microsecond ticks
   // ------------------------------------------------------------
   localparam logic [31:0] FACT_RST_US  = 32'h0003_0d40; // 200 ms
   localparam logic [31:0] CAP_RST_US   = 32'h0004_e9d0; // 322 ms
   localparam logic [31:0] CAP_WDU_US   = 32'h0000_f514; // 62.74 ms
   localparam logic [31:0] NC00_WDL_US  = 32'h0000_57e4; // 22.5 ms
   localparam logic [31:0] NC00_WDU_US  = 32'h0000_d6d8; // 55.0 ms
   localparam logic [31:0] NC01_WDL_US  = 32'h0000_073a; // 1.85 ms
   localparam logic [31:0] NC01_WDU_US  = 32'h0000_6b6c; // 27.5 ms
   localparam logic [31:0] NC11_WDL_US  = 32'h000c_3500; // 800 ms
   localparam logic [31:0] NC11_WDU_US  = 32'h0018_6a00; // 1.6 s
   localparam logic [31:0] PU00_WDL_US  = 32'h0000_2328; // 9.0 ms
   localparam logic [31:0] PU00_WDU_US  = 32'h0001_a9c8; // 109 ms
   localparam logic [31:0] PU01_WDL_US  = 32'h0000_2328; // 9.0 ms
   localparam logic [31:0] PU01_WDU_US  = 32'h0002_f9b8; // 195 ms
   localparam logic [31:0] PU11_WDL_US  = 32'h0000_073a; // 1.85 ms
   localparam logic [31:0] PU11_WDU_US  = 32'h0000_2af8; // 11.0 ms

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_STATUS   = 8'h00;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h04;
   localparam logic [7:0] ADR_IRQ_CLR  = 8'h08;
   localparam logic [7:0] ADR_IRQ_EN   = 8'h0c;
   localparam logic [7:0] ADR_WDU_US   = 8'h10;
   localparam logic [7:0] ADR_RST_US   = 8'h14;

   localparam int IRQ_EARLY   = 0;
   localparam int IRQ_TIMEOUT = 1;
   localparam int IRQ_RELEASE = 2;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SETTING_OPEN   = 2'b00,
      SETTING_PULLUP = 2'b01,
      SETTING_CAP    = 2'b10
   } wwdt_setting_t;

   typedef enum logic [1:0] {
      ST_OFF   = 2'b00,
      ST_WATCH = 2'b01,
      ST_FAULT = 2'b10
   } wwdt_state_t;

   typedef struct packed {
      logic       kick;
      logic       sel_hi;
      logic       sel_lo;
      logic [1:0] win;
      logic [1:0] rst;
      logic       line;
   } wwdt_strap_t;

   typedef struct packed {
      logic        off;
      logic [31:0] lo;
      logic [31:0] hi;
   } wwdt_win_t;

endpackage

`default_nettype wire

// [core/wwdt_top.sv]
`default_nettype none

// How it works
// - a kick before the lower bound is a fault; the fault line goes low.
// - no kick by the upper bound is a fault; a late kick never counts.
// - each missed timeout pulls the line low for the reset delay, repeating.
// - kicks inside the window keep the fault line released high.
// - reset delay from capacitor, pull-up or open strap; latter two factory.
// - open reset-delay strap gives the factory delay of 200 ms.
// - capacitor option uses the programmed delay, default 322 ms.
// - open window strap, both selects high: 800 ms to 1.6 s window.
// - open window strap, both selects low: 22.5 ms to 55 ms window.
// - fault output is open drain: drives low only, else released.
// - capacitor window: selects fix lower to upper bound ratio only.
module wwdt_top #(
   parameter int TICK_CYC = wwdt_pkg::TICK_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // pins
   input  wire logic        kick_pulse_in_i,
   input  wire logic        window_select_lo_i,
   input  wire logic        window_select_hi_i,
   input  wire logic [1:0]  window_setting_i,
   input  wire logic [1:0]  reset_delay_setting_i,
   input  wire logic        fault_out_n_i,
   output var  logic        fault_out_n_o,
   output var  logic        fault_out_n_oe_o,
   output var  logic        irq_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      wwdt_pkg::wwdt_strap_t sync1;
      wwdt_pkg::wwdt_strap_t sync2;
      logic                  kick_prev;
      wwdt_pkg::wwdt_state_t st;
      logic [15:0]           tick_cnt;
      logic [31:0]           cnt;
      logic [2:0]            irq_stat;
      logic [2:0]            irq_en;
      logic [31:0]           wdu_us;
      logic [31:0]           rst_us;
      logic                  ack;
      logic [31:0]           dat;
      logic                  irq;
      logic                  oe;
      logic                  od;
   } wwdt_regs_t;

   // straps read as the disable code until the synchronisers fill
   localparam wwdt_pkg::wwdt_strap_t STRAP_IDLE = '{
      kick:   1'b1,
      sel_hi: 1'b0,
      sel_lo: 1'b1,
      win:    2'b11,
      rst:    2'b11,
      line:   1'b1
   };

   localparam wwdt_regs_t RESET_STATE = '{
      sync1:     STRAP_IDLE,
      sync2:     STRAP_IDLE,
      kick_prev: 1'b1,
      st:        wwdt_pkg::ST_OFF,
      tick_cnt:  16'h0000,
      cnt:       32'h0000_0000,
      irq_stat:  3'h0,
      irq_en:    3'h0,
      wdu_us:    wwdt_pkg::CAP_WDU_US,
      rst_us:    wwdt_pkg::CAP_RST_US,
      ack:       1'b0,
      dat:       32'h0000_0000,
      irq:       1'b0,
      oe:        1'b0,
      od:        1'b0
   };

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

   wwdt_regs_t s_q;
   wwdt_regs_t s_d;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // byte-lane merge for wishbone writes
   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old,
      input logic [31:0] wdat,
      input logic [3:0]  sel
   );
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = wdat[8*i +: 8];
         end
      end
      return r;
   endfunction

   // window bounds from the straps
   function automatic wwdt_pkg::wwdt_win_t window_of(
      input wwdt_pkg::wwdt_strap_t st,
      input logic [31:0]           cap_wdu
   );
      wwdt_pkg::wwdt_win_t w;
      logic [1:0]          sel;
      sel   = {st.sel_lo, st.sel_hi};
      w.off = (sel == 2'b10);
      w.lo  = 32'h0000_0000;
      w.hi  = 32'hffff_ffff;
      if (st.win == wwdt_pkg::SETTING_CAP) begin
         w.hi = cap_wdu;
         case (sel)
            2'b00: w.lo = {3'b000, cap_wdu[31:3]};
            2'b01: w.lo = cap_wdu - {2'b00, cap_wdu[31:2]};
            2'b11: w.lo = {1'b0, cap_wdu[31:1]};
            default: w.lo = 32'h0000_0000;
         endcase
      end else if (st.win == wwdt_pkg::SETTING_PULLUP) begin
         case (sel)
            2'b00: begin
               w.lo = wwdt_pkg::PU00_WDL_US;
               w.hi = wwdt_pkg::PU00_WDU_US;
            end
            2'b01: begin
               w.lo = wwdt_pkg::PU01_WDL_US;
               w.hi = wwdt_pkg::PU01_WDU_US;
            end
            2'b11: begin
               w.lo = wwdt_pkg::PU11_WDL_US;
               w.hi = wwdt_pkg::PU11_WDU_US;
            end
            default: begin
               w.lo = 32'h0000_0000;
            end
         endcase
      end else begin
         // open strap, and any unused code treated as open
         case (sel)
            2'b00: begin
               w.lo = wwdt_pkg::NC00_WDL_US;
               w.hi = wwdt_pkg::NC00_WDU_US;
            end
            2'b01: begin
               w.lo = wwdt_pkg::NC01_WDL_US;
               w.hi = wwdt_pkg::NC01_WDU_US;
            end
            2'b11: begin
               w.lo = wwdt_pkg::NC11_WDL_US;
               w.hi = wwdt_pkg::NC11_WDU_US;
            end
            default: begin
               w.lo = 32'h0000_0000;
            end
         endcase
      end
      return w;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   wwdt_pkg::wwdt_strap_t pins;
   wwdt_pkg::wwdt_win_t   win;
   logic [31:0]           rst_delay;
   logic [31:0]           cnt_inc;
   logic                  tick;
   logic                  kick_rise;
   logic                  req;
   logic [2:0]            ev;
   logic [2:0]            clr;
   logic [31:0]           mrg;

   always_comb begin
      pins.kick   = kick_pulse_in_i;
      pins.sel_hi = window_select_hi_i;
      pins.sel_lo = window_select_lo_i;
      pins.win    = window_setting_i;
      pins.rst    = reset_delay_setting_i;
      pins.line   = fault_out_n_i;
   end

   always_comb begin
      s_d = s_q;
      ev  = 3'h0;
      clr = 3'h0;
      mrg = 32'h0000_0000;

      // two-stage synchronisers on every pin
      s_d.sync1 = pins;
      s_d.sync2 = s_q.sync1;

      // microsecond tick; the trade is 1 us resolution for narrow compares
      tick = (s_q.tick_cnt >= TICK_LAST);
      s_d.tick_cnt = tick ? 16'h0000 : s_q.tick_cnt + 16'h0001;

      kick_rise   = s_q.sync2.kick & ~s_q.kick_prev;
      s_d.kick_prev = s_q.sync2.kick;

      win = window_of(s_q.sync2, s_q.wdu_us);
      if (s_q.sync2.rst == wwdt_pkg::SETTING_CAP) begin
         rst_delay = s_q.rst_us;
      end else begin
         rst_delay = wwdt_pkg::FACT_RST_US;
      end
      cnt_inc = s_q.cnt + 32'h0000_0001;

      // ---------------------------------------------------------
      // watchdog sequence
      // ---------------------------------------------------------
      case (s_q.st)
         wwdt_pkg::ST_OFF: begin
            s_d.cnt = 32'h0000_0000;
            if (!win.off) begin
               s_d.st = wwdt_pkg::ST_WATCH;
            end
         end
         wwdt_pkg::ST_WATCH: begin
            if (win.off) begin
               s_d.st  = wwdt_pkg::ST_OFF;
               s_d.cnt = 32'h0000_0000;
            end else if (kick_rise) begin
               s_d.cnt = 32'h0000_0000;
               if (s_q.cnt < win.lo) begin
                  s_d.st = wwdt_pkg::ST_FAULT;
                  ev[wwdt_pkg::IRQ_EARLY] = 1'b1;
               end
               // else a good kick: line stays released
            end else if (tick) begin
               if (cnt_inc >= win.hi) begin
                  s_d.st  = wwdt_pkg::ST_FAULT;
                  s_d.cnt = 32'h0000_0000;
                  ev[wwdt_pkg::IRQ_TIMEOUT] = 1'b1;
               end else begin
                  s_d.cnt = cnt_inc;
               end
            end
         end
         wwdt_pkg::ST_FAULT: begin
            // kicks are not looked at while the line is held low
            if (tick) begin
               if (cnt_inc >= rst_delay) begin
                  s_d.st  = wwdt_pkg::ST_WATCH;
                  s_d.cnt = 32'h0000_0000;
                  ev[wwdt_pkg::IRQ_RELEASE] = 1'b1;
               end else begin
                  s_d.cnt = cnt_inc;
               end
            end
         end
         default: begin
            s_d.st  = wwdt_pkg::ST_OFF;
            s_d.cnt = 32'h0000_0000;
         end
      endcase

      // ---------------------------------------------------------
      // wishbone slave, one wait state
      // ---------------------------------------------------------
      req     = wb_cyc_i & wb_stb_i & ~s_q.ack;
      s_d.ack = req;
      if (req && wb_we_i) begin
         case (wb_adr_i)
            wwdt_pkg::ADR_IRQ_CLR: begin
               mrg = merge_bytes(32'h0000_0000, wb_dat_i, wb_sel_i);
               clr = mrg[2:0];
            end
            wwdt_pkg::ADR_IRQ_EN: begin
               mrg        = merge_bytes({29'h0, s_q.irq_en},
                                        wb_dat_i, wb_sel_i);
               s_d.irq_en = mrg[2:0];
            end
            wwdt_pkg::ADR_WDU_US: begin
               s_d.wdu_us = merge_bytes(s_q.wdu_us, wb_dat_i, wb_sel_i);
            end
            wwdt_pkg::ADR_RST_US: begin
               s_d.rst_us = merge_bytes(s_q.rst_us, wb_dat_i, wb_sel_i);
            end
            default: begin
               s_d.irq_en = s_q.irq_en;
            end
         endcase
      end
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            wwdt_pkg::ADR_STATUS: begin
               s_d.dat = {23'h00_0000, s_q.sync2.rst, s_q.sync2.win,
                          s_q.sync2.sel_hi, s_q.sync2.sel_lo,
                          s_q.sync2.line, s_q.st};
            end
            wwdt_pkg::ADR_IRQ_STAT: s_d.dat = {29'h0, s_q.irq_stat};
            wwdt_pkg::ADR_IRQ_EN:   s_d.dat = {29'h0, s_q.irq_en};
            wwdt_pkg::ADR_WDU_US:   s_d.dat = s_q.wdu_us;
            wwdt_pkg::ADR_RST_US:   s_d.dat = s_q.rst_us;
            default:                s_d.dat = 32'h0000_0000;
         endcase
      end

      // ---------------------------------------------------------
      // interrupts: a new event beats a clear in the same cycle
      // ---------------------------------------------------------
      s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
      s_d.irq      = |(s_d.irq_stat & s_d.irq_en);

      // only ever pulls low; the pull-up makes the high level
      s_d.oe = (s_d.st == wwdt_pkg::ST_FAULT);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= RESET_STATE;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign wb_dat_o         = s_q.dat;
   assign wb_ack_o         = s_q.ack;
   // open-drain data bit: always low, kept in a flop like every output
   assign fault_out_n_o    = s_q.od;
   assign fault_out_n_oe_o = s_q.oe;
   assign irq_o            = s_q.irq;

endmodule

`default_nettype wire

// [test/wwdt_top_sva.sv]
`default_nettype none
module wwdt_top_sva #(
   parameter int TICK_CYC = 1,
   parameter int LO_US    = 50,
   parameter int HI_US    = 400,
   parameter int RST_US   = 100
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       kick_pulse_in_i,
   input wire logic       window_select_lo_i,
   input wire logic       window_select_hi_i,
   input wire logic [1:0] window_setting_i,
   input wire logic [1:0] reset_delay_setting_i,
   input wire logic       fault_out_n_o,
   input wire logic       fault_out_n_oe_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------
   // window tracking
   // ------------------------------------
   // limits match the bench setup; window and delay checks sleep under other straps
   localparam int LO = LO_US * TICK_CYC;
   localparam int HI = HI_US * TICK_CYC;
   localparam int RS = RST_US * TICK_CYC;
   logic [31:0] cnt_q;
   logic [31:0] hold_q;
   logic        kick_q;
   logic        oe_q;
   logic        rise;
   logic        oe;
   logic        cfg;
   assign oe = fault_out_n_oe_o;
   assign rise = kick_pulse_in_i && !kick_q;
   assign cfg = window_setting_i == 2'b10 && reset_delay_setting_i == 2'b10
                && !window_select_lo_i && !window_select_hi_i;
   always_ff @(posedge clk_i) begin
      kick_q <= kick_pulse_in_i;
      oe_q   <= oe;
      if (rst_i || (oe_q && !oe) || (rise && !oe))
         cnt_q <= 32'h0000_0000;
      else
         cnt_q <= cnt_q + 32'h0000_0001;
      hold_q <= (rst_i || !oe) ? 32'h0000_0000 : hold_q + 32'h0000_0001;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_held; oe [*8]; endsequence
   sequence s_quiet; !oe [*8]; endsequence
   a_od_low: assert property (fault_out_n_o == 1'b0)
      else $error("fault data pin not low");
   a_fault_held: assert property ($rose(oe) && cfg |-> s_held)
      else $error("fault released too soon");
   a_delay_len: assert property ($fell(oe) && cfg |->
      hold_q >= RS - 1 && hold_q <= RS + 2) else $error("bad delay");
   a_early_fault: assert property (rise && !oe && cfg
      && cnt_q < LO - 4 |-> ##[1:6] oe) else $error("early kick passed");
   a_good_quiet: assert property (rise && !oe && cfg && cnt_q > LO + 4
      && cnt_q < HI - 8 |=> s_quiet) else $error("good kick faulted");
   a_late_fault: assert property (cfg && cnt_q == HI + 8 |-> oe)
      else $error("no fault at timeout");
   a_kick_ignored: assert property (rise && oe && cfg
      && hold_q < RS - 20 |=> s_held) else $error("kick ended fault");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack late");
endmodule
bind wwdt_top wwdt_top_sva #(.TICK_CYC(TICK_CYC)) u_sva (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .kick_pulse_in_i(kick_pulse_in_i),
   .window_select_lo_i(window_select_lo_i),
   .window_select_hi_i(window_select_hi_i),
   .window_setting_i(window_setting_i),
   .reset_delay_setting_i(reset_delay_setting_i),
   .fault_out_n_o(fault_out_n_o), .fault_out_n_oe_o(fault_out_n_oe_o));
`default_nettype wire

// [test/wwdt_mcu.sv]
`default_nettype none
module wwdt_mcu (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        line_i,
   input  wire logic [15:0] period_i,
   output var  logic        kick_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------
   // kick generator
   // ------------------------------------
   // kicks go on while the line is low: the wire feeds an interrupt,
   // not this controller's reset, so the block must ignore them
   logic [15:0] cnt_q;
   logic [2:0]  pw_q;
   logic        line_q;
   always_ff @(posedge clk_i) begin
      line_q <= line_i;
      if (rst_i || (line_i && !line_q) ||
          (period_i != 16'h0000 && cnt_q >= period_i))
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_q + 16'h0001;
      if (rst_i)
         pw_q <= 3'h0;
      else if (period_i != 16'h0000 && cnt_q == period_i)
         pw_q <= 3'h4;
      else if (pw_q != 3'h0)
         pw_q <= pw_q - 3'h1;
   end
   assign kick_o = (pw_q != 3'h0);
endmodule
`default_nettype wire

// [test/wwdt_top_bench.sv]
`default_nettype none
module wwdt_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------
   // stimulus, monitors and checks
   // ------------------------------------
   localparam int LIMIT = 80000;
   logic        clk_i  = 1'b0;
   logic        rst_i  = 1'b1;
   logic        cyc    = 1'b0;
   logic        we     = 1'b0;
   logic [7:0]  adr    = 8'h00;
   logic [3:0]  sel    = 4'h0;
   logic [31:0] wdat   = 32'h0000_0000;
   logic        s_lo   = 1'b0;
   logic        s_hi   = 1'b0;
   logic [1:0]  win    = 2'b10;
   logic [15:0] period = 16'h0000;
   logic [31:0] rdat, q;
   logic        ack, irq, oe, od, kick, line;
   logic        oe_q   = 1'b0;
   int          mismatches = 0;
   int          n_compared = 0;
   int          cycles = 0, n_rise = 0, hold = 0, last_len = 0, r0 = 0;
   logic [1:0]  rsel [3] = '{2'b10, 2'b11, 2'b01};
   logic [15:0] rper [3] = '{16'h00c8, 16'h00fa, 16'h0014};
   logic [31:0] rexp [3] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0000};
   always #2.5 clk_i = ~clk_i;
   // pull-up on the open-drain fault wire
   assign line = oe ? 1'b0 : 1'b1;
   wwdt_top #(.TICK_CYC(1)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .kick_pulse_in_i(kick), .window_select_lo_i(s_lo),
      .window_select_hi_i(s_hi), .window_setting_i(win),
      .reset_delay_setting_i(2'b10), .fault_out_n_i(line),
      .fault_out_n_o(od), .fault_out_n_oe_o(oe), .irq_o(irq));
   wwdt_mcu u_mcu (.clk_i(clk_i), .rst_i(rst_i), .line_i(line),
      .period_i(period), .kick_o(kick));
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t value got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_rng(input int g, input int lo, input int hi);
      n_compared++;
      if (g < lo || g > hi) begin
         mismatches++;
         $display("[ERR] %0t count %0d not in %0d..%0d", $time, g, lo, hi);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0000_0000, 4'hf);
   endtask
   task automatic clr_wait(input int n);
      xfer(1'b1, 8'h08, 32'h0000_0007, 4'hf);
      r0 = n_rise;
      repeat (n) @(posedge clk_i);
   endtask
   task automatic rst_pulse();
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      oe_q <= oe;
      hold <= oe ? hold + 1 : 0;
      if (oe_q && !oe)
         last_len <= hold;
      if (oe && !oe_q)
         n_rise <= n_rise + 1;
      if (cycles == LIMIT) begin
         mismatches++;
         $display("[ERR] %0t run too long", $time);
         stop_test();
      end
   end
   initial begin
      rst_pulse();
      rd(8'h10);
      cmp(q, 32'h0000_f514);
      rd(8'h14);
      cmp(q, 32'h0004_e9d0);
      rd(8'h20);
      cmp(q, 32'h0000_0000);
      xfer(1'b1, 8'h00, 32'hffff_ffff, 4'hf);
      rd(8'h00);
      cmp(q, 32'h0000_0145);
      xfer(1'b1, 8'h10, 32'hffff_0190, 4'h3);
      rd(8'h10);
      cmp(q, 32'h0000_0190);
      xfer(1'b1, 8'h14, 32'h0000_0064, 4'hf);
      xfer(1'b1, 8'h0c, 32'h0000_0007, 4'hf);
      $display("registers done");
      period <= 16'h0014;
      clr_wait(1000);
      rd(8'h04);
      cmp(q, 32'h0000_0005);
      cmp_rng(last_len, 99, 102);
      cmp({31'h0, irq}, 32'h0000_0001);
      xfer(1'b1, 8'h0c, 32'h0000_0002, 4'hf);
      repeat (2) @(posedge clk_i);
      cmp({31'h0, irq}, 32'h0000_0000);
      xfer(1'b1, 8'h0c, 32'h0000_0007, 4'hf);
      $display("early kick done");
      period <= 16'h00c8;
      clr_wait(600);
      clr_wait(1500);
      cmp_rng(n_rise - r0, 0, 0);
      cmp({31'h0, irq}, 32'h0000_0000);
      $display("recovery done");
      period <= 16'h01c2;
      clr_wait(600);
      clr_wait(1100);
      cmp_rng(n_rise - r0, 2, 3);
      rd(8'h04);
      cmp(q, 32'h0000_0006);
      $display("late kick done");
      for (int i = 0; i < 3; i++) begin
         {s_hi, s_lo} <= rsel[i];
         period <= rper[i];
         clr_wait(1000);
         clr_wait(1500);
         rd(8'h04);
         cmp(q & 32'h0000_0001, rexp[i]);
      end
      $display("ratio table done");
      {s_hi, s_lo} <= 2'b00;
      win <= 2'b00;
      period <= 16'h5dc0;
      rst_pulse();
      clr_wait(50000);
      rd(8'h04);
      cmp(q, 32'h0000_0000);
      cmp_rng(n_rise - r0, 0, 0);
      $display("open strap done");
      stop_test();
   end
endmodule
`default_nettype wire
